// >>> hdl/frc_params.svh
// named offsets, fields, reset values and timing constants of the fault/retry configuration block
`ifndef FRC_PARAMS_SVH
`define FRC_PARAMS_SVH

// command codes
`define FR_CMD_REGULATION 8'hc5
`define FR_CMD_FAULT_UNITS 8'hc8
`define FR_CMD_BUS_SETUP 8'hc9
`define FR_CMD_FAST_OC 8'hca

// regulation_setup fields
`define FR_DIODE_EMU 0

// fault_delay_units fields
`define FR_VOUT_UNIT 7:6
`define FR_VIN_UNIT 5:4
`define FR_IOUT_UNIT 3:2
`define FR_TEMP_UNIT 1:0

// bus_address_pin_setup fields
`define FR_PG_POL 33
`define FR_CTL_POL 32
`define FR_BASE_ADDR 31:24
`define FR_ADDR_OFS 23:17
`define FR_OFS_EN 16

// fast_overcurrent_response fields and codes
`define FR_RESP 7:6
`define FR_RETRIES 5:3
`define FR_RTIME 2:0
`define FR_RESP_IGNORE 2'h0
`define FR_RESP_RETRY 2'h3
`define FR_RETRY_NONE 3'h0
`define FR_RETRY_FOREVER 3'h7

// reset values
`define FR_RST_REGULATION 8'h00
`define FR_RST_FAULT_UNITS 8'h00
`define FR_RST_BUS_SETUP 34'h000000000
`define FR_RST_FAST_OC 8'h00

// time units in ms per code
`define FR_UNIT0_MS 16'h0001
`define FR_UNIT1_MS 16'h0004
`define FR_UNIT2_MS 16'h0010
`define FR_UNIT3_MS 16'h0100

// timing
`define FR_MS_NS 1000000
`define FR_CLK_NS 4
`define FR_TICK_W 18
`define FR_STRAP_WAIT 2'h3

`endif

// >>> hdl/frc_pkg.sv
// types of the fault/retry configuration block
package frc_pkg;
	typedef enum logic [2:0] {
		FRC_IDLE,
		FRC_HOLD,
		FRC_OFF,
		FRC_RERUN,
		FRC_LATCH
	} frc_state_t;
endpackage

// >>> hdl/frc_sync2.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module frc_sync2 #(
	parameter int unsigned W = 1
) (
	// clock and reset
	input  wire logic         sys_clk,
	input  wire logic         rst,
	// data
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] meta;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			meta <= '0;
			dout <= '0;
		end else begin
			meta <= din;
			dout <= meta;
		end
	end
endmodule // frc_sync2

// >>> hdl/frc_ms_tick.sv
// millisecond enable pulse from the system clock
`timescale 1ns/1ps
`include "frc_params.svh"
module frc_ms_tick #(
	parameter int unsigned CYCLES = `FR_MS_NS / `FR_CLK_NS
) (
	// clock and reset
	input  wire logic sys_clk,
	input  wire logic rst,
	// control
	input  wire logic align,
	output logic      tick
);
	logic [`FR_TICK_W-1:0] cnt;
	logic [`FR_TICK_W-1:0] next_cnt;
	logic                  next_tick;

	// align restarts the period so a delay starts on a full millisecond
	always_comb begin
		next_tick = 1'b0;
		if (align) begin
			next_cnt = '0;
		end else if (cnt == `FR_TICK_W'(CYCLES - 1)) begin
			next_cnt  = '0;
			next_tick = 1'b1;
		end else begin
			next_cnt = cnt + `FR_TICK_W'(1);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			cnt  <= '0;
			tick <= 1'b0;
		end else begin
			cnt  <= next_cnt;
			tick <= next_tick;
		end
	end
endmodule // frc_ms_tick

// >>> hdl/frc_regs.sv
// fault/retry configuration registers and fast overcurrent retry control
//
// Overview of operation
// R1 - regulation bit 0 enables startup diode emulation
// R2 - fault units bits 7:6 set output-voltage unit
// R3 - fault units bits 5:4 set input-voltage unit
// R4 - fault units bits 3:2 set output-current unit
// R5 - fault units bits 1:0 set temperature unit
// R6 - bus setup bits 31:24 hold base address
// R7 - stored offset 23:17 used when strap disabled
// R8 - bit 16 selects strap resistor offset
// R9 - bit 33 sets power-good polarity
// R10 - bit 32 sets control pin polarity
// R11 - any response sets status and notifies host
// R12 - code 00 keeps running at normal limit
// R13 - code 11 holds fast limit, then retry
// R14 - retries 000 latch off, 111 forever
// R15 - bits 2:0 give hold and spacing delay
// R16 - delay code n means 2^n units
// R17 - unit duration taken from fault units register
// R18 - fast delays timed by current unit, ms tick
`timescale 1ns/1ps
`include "frc_params.svh"
module frc_regs #(
	parameter int unsigned MS_CYCLES = `FR_MS_NS / `FR_CLK_NS
) (
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst,
	// command port
	input  wire logic        cmd_valid,
	input  wire logic        cmd_write,
	input  wire logic [7:0]  cmd_code,
	input  wire logic [33:0] cmd_wdata,
	input  wire logic        clear_fault,
	output logic             cmd_ack,
	output logic             cmd_err,
	output logic [33:0]      cmd_rdata,
	// pins
	input  wire logic        ctrl_pin,
	input  wire logic        fast_oc_pin,
	input  wire logic [6:0]  addr_strap,
	output logic             pgood_pin,
	// power stage
	input  wire logic        power_ok,
	output logic             output_en,
	output logic             diode_emu_en,
	output logic             fast_limit_sel,
	// configuration out
	output logic [7:0]       bus_address,
	output logic [1:0]       vout_unit,
	output logic [1:0]       vin_unit,
	output logic [1:0]       iout_unit,
	output logic [1:0]       temp_unit,
	// status
	output logic             fast_oc_status,
	output logic             host_notify
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);

	// delay in ms for a unit code and a 2^n count
	function automatic logic [15:0] delay_ms(input logic [1:0] unit, input logic [2:0] n);
		logic [15:0] base;
		base = `FR_UNIT0_MS;
		case (unit)
			2'h0: base = `FR_UNIT0_MS;
			2'h1: base = `FR_UNIT1_MS;
			2'h2: base = `FR_UNIT2_MS;
			default: base = `FR_UNIT3_MS;
		endcase
		return base << n;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// pin synchronisers and ms tick

	logic [8:0] pins_s;
	logic       ctl_s;
	logic       oc_s;
	logic [6:0] strap_s;
	logic       tick;
	logic       align;

	frc_sync2 #(.W(9)) u_sync (
		.sys_clk (sys_clk),
		.rst     (rst),
		.din     ({ctrl_pin, fast_oc_pin, addr_strap}),
		.dout    (pins_s)
	);

	assign ctl_s   = pins_s[8];
	assign oc_s    = pins_s[7];
	assign strap_s = pins_s[6:0];

	frc_ms_tick #(.CYCLES(MS_CYCLES)) u_tick (
		.sys_clk (sys_clk),
		.rst     (rst),
		.align   (align),
		.tick    (tick)
	);

	////////////////////////////////////////////////////////////////////////////////
	// registers and command port

	logic [7:0]  regulation_setup;
	logic [7:0]  fault_delay_units;
	logic [33:0] bus_address_pin_setup;
	logic [7:0]  fast_overcurrent_response;
	logic [7:0]  next_regulation_setup;
	logic [7:0]  next_fault_delay_units;
	logic [33:0] next_bus_address_pin_setup;
	logic [7:0]  next_fast_overcurrent_response;
	logic        next_cmd_ack;
	logic        next_cmd_err;
	logic [33:0] next_cmd_rdata;
	logic        wr;

	always_comb begin
		wr                             = cmd_valid && cmd_write;
		next_regulation_setup          = regulation_setup;
		next_fault_delay_units         = fault_delay_units;
		next_bus_address_pin_setup     = bus_address_pin_setup;
		next_fast_overcurrent_response = fast_overcurrent_response;
		next_cmd_ack                   = cmd_valid;
		next_cmd_err                   = 1'b0;
		next_cmd_rdata                 = '0;
		// bits above a register's width are dropped on write, read as zero
		case (cmd_code)
			`FR_CMD_REGULATION: begin
				if (wr)
					next_regulation_setup = cmd_wdata[7:0];
				next_cmd_rdata = {26'h0, regulation_setup};
			end
			`FR_CMD_FAULT_UNITS: begin
				if (wr)
					next_fault_delay_units = cmd_wdata[7:0];
				next_cmd_rdata = {26'h0, fault_delay_units};
			end
			`FR_CMD_BUS_SETUP: begin
				if (wr)
					next_bus_address_pin_setup = cmd_wdata;
				next_cmd_rdata = bus_address_pin_setup;
			end
			`FR_CMD_FAST_OC: begin
				if (wr)
					next_fast_overcurrent_response = cmd_wdata[7:0];
				next_cmd_rdata = {26'h0, fast_overcurrent_response};
			end
			default: next_cmd_err = cmd_valid;
		endcase
		if (!cmd_valid)
			next_cmd_rdata = '0;
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			regulation_setup          <= `FR_RST_REGULATION;
			fault_delay_units         <= `FR_RST_FAULT_UNITS;
			bus_address_pin_setup     <= `FR_RST_BUS_SETUP;
			fast_overcurrent_response <= `FR_RST_FAST_OC;
			cmd_ack                   <= 1'b0;
			cmd_err                   <= 1'b0;
			cmd_rdata                 <= '0;
		end else begin
			regulation_setup          <= next_regulation_setup;
			fault_delay_units         <= next_fault_delay_units;
			bus_address_pin_setup     <= next_bus_address_pin_setup;
			fast_overcurrent_response <= next_fast_overcurrent_response;
			cmd_ack                   <= next_cmd_ack;
			cmd_err                   <= next_cmd_err;
			cmd_rdata                 <= next_cmd_rdata;
		end
	end

	assign diode_emu_en = regulation_setup[`FR_DIODE_EMU]; // [R1]
	assign vout_unit    = fault_delay_units[`FR_VOUT_UNIT]; // [R2]
	assign vin_unit     = fault_delay_units[`FR_VIN_UNIT]; // [R3]
	assign iout_unit    = fault_delay_units[`FR_IOUT_UNIT]; // [R4]
	assign temp_unit    = fault_delay_units[`FR_TEMP_UNIT]; // [R5]

	a_diode_follow: assert property (wr && cmd_code == `FR_CMD_REGULATION // [R1]
		|=> diode_emu_en == $past(cmd_wdata[`FR_DIODE_EMU])) else $error("diode bit not stored");
	a_unit_store: assert property (wr && cmd_code == `FR_CMD_FAULT_UNITS // [R2]
		|=> vout_unit == $past(cmd_wdata[7:6]) && temp_unit == $past(cmd_wdata[1:0]))
		else $error("unit selectors not stored");

	////////////////////////////////////////////////////////////////////////////////
	// fast overcurrent fault handling

	frc_pkg::frc_state_t state;
	frc_pkg::frc_state_t next_state;
	logic [15:0] ms_left;
	logic [15:0] next_ms_left;
	logic [2:0]  tries;
	logic [2:0]  next_tries;
	logic        expired;
	logic [1:0]  resp;
	logic [2:0]  retries;
	logic [15:0] fast_delay;

	assign resp       = fast_overcurrent_response[`FR_RESP];
	assign retries    = fast_overcurrent_response[`FR_RETRIES];
	assign fast_delay = delay_ms(iout_unit, fast_overcurrent_response[`FR_RTIME]); // [R15] [R16] [R17] [R18]

	always_comb begin
		next_state   = state;
		next_ms_left = ms_left;
		next_tries   = tries;
		align        = 1'b0;
		expired      = tick && (ms_left == 16'h0001);
		if (tick && ms_left != 16'h0000)
			next_ms_left = ms_left - 16'h0001;
		case (state)
			frc_pkg::FRC_IDLE: begin
				// codes other than 11 run on, as ignore does
				if (oc_s && resp == `FR_RESP_RETRY) begin // [R13]
					next_state   = frc_pkg::FRC_HOLD;
					next_ms_left = fast_delay;
					next_tries   = retries;
					align        = 1'b1;
				end
			end
			frc_pkg::FRC_HOLD: begin
				if (!oc_s || resp != `FR_RESP_RETRY) begin
					next_state = frc_pkg::FRC_IDLE;
				end else if (expired) begin
					if (tries == `FR_RETRY_NONE) begin // [R14]
						next_state = frc_pkg::FRC_LATCH;
					end else begin
						next_state   = frc_pkg::FRC_OFF;
						next_ms_left = fast_delay; // [R15]
						align        = 1'b1;
						if (tries != `FR_RETRY_FOREVER) // [R14]
							next_tries = tries - 3'h1;
					end
				end
			end
			frc_pkg::FRC_OFF: begin
				if (expired) begin
					next_state   = frc_pkg::FRC_RERUN;
					next_ms_left = fast_delay;
					align        = 1'b1;
				end
			end
			frc_pkg::FRC_RERUN: begin
				// a clean delay after restart counts as recovered
				if (oc_s && resp == `FR_RESP_RETRY) begin
					next_state   = frc_pkg::FRC_HOLD;
					next_ms_left = fast_delay;
					align        = 1'b1;
				end else if (expired) begin
					next_state = frc_pkg::FRC_IDLE;
				end
			end
			frc_pkg::FRC_LATCH: begin
				if (clear_fault) // [R14]
					next_state = frc_pkg::FRC_IDLE;
			end
			default: next_state = frc_pkg::FRC_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state   <= frc_pkg::FRC_IDLE;
			ms_left <= '0;
			tries   <= '0;
		end else begin
			state   <= next_state;
			ms_left <= next_ms_left;
			tries   <= next_tries;
		end
	end

	sequence s_expire_retry;
		state == frc_pkg::FRC_HOLD && oc_s && resp == `FR_RESP_RETRY && expired;
	endsequence

	sequence s_off_window;
		state == frc_pkg::FRC_OFF && !output_en;
	endsequence

	a_hold_load: assert property ($rose(state == frc_pkg::FRC_HOLD) // [R16]
		|-> ms_left == $past(fast_delay)) else $error("hold delay not 2^n units");
	a_hold_retry: assert property (s_expire_retry ##0 tries != `FR_RETRY_NONE |=> s_off_window) // [R13]
		else $error("no shutdown after hold delay");
	a_no_retry: assert property (s_expire_retry ##0 tries == `FR_RETRY_NONE // [R14]
		|=> state == frc_pkg::FRC_LATCH && !output_en) else $error("zero retries not latched");
	a_retry_forever: assert property (s_expire_retry ##0 tries == `FR_RETRY_FOREVER // [R14]
		|=> tries == `FR_RETRY_FOREVER) else $error("continuous retry count changed");
	// a clear in the second cycle may end the latch, so both cycles must be clear-free
	a_latch_stays: assert property (state == frc_pkg::FRC_LATCH && !clear_fault ##1 !clear_fault // [R14]
		|-> state == frc_pkg::FRC_LATCH ##1 state == frc_pkg::FRC_LATCH && !output_en)
		else $error("latched output restarted");

	////////////////////////////////////////////////////////////////////////////////
	// status, notify, strap capture and outputs

	logic       oc_d;
	logic       fault_rise;
	logic       ctl_act;
	logic [1:0] strap_cnt;
	logic [1:0] next_strap_cnt;
	logic [6:0] strap_q;
	logic [6:0] next_strap_q;
	logic [6:0] ofs;
	logic       next_fast_oc_status;
	logic       next_host_notify;
	logic       next_output_en;
	logic       next_pgood_pin;
	logic       next_fast_limit_sel;
	logic [7:0] next_bus_address;

	always_comb begin
		fault_rise = oc_s && !oc_d;
		ctl_act    = ctl_s ~^ bus_address_pin_setup[`FR_CTL_POL]; // [R10]
		// the strap is caught once the synchroniser has filled after reset
		next_strap_cnt = strap_cnt;
		next_strap_q   = strap_q;
		if (strap_cnt != `FR_STRAP_WAIT) begin
			next_strap_cnt = strap_cnt + 2'h1;
			next_strap_q   = strap_s;
		end
		ofs = bus_address_pin_setup[`FR_OFS_EN] ? strap_q : // [R8]
			bus_address_pin_setup[`FR_ADDR_OFS]; // [R7]
		next_bus_address = bus_address_pin_setup[`FR_BASE_ADDR] + {1'b0, ofs}; // [R6]
		// a new fault beats a clear in the same cycle
		next_fast_oc_status = fault_rise || (fast_oc_status && !clear_fault); // [R11]
		next_host_notify    = fault_rise; // [R11]
		next_output_en      = ctl_act && next_state != frc_pkg::FRC_OFF && // [R12]
			next_state != frc_pkg::FRC_LATCH; // [R13]
		next_fast_limit_sel = resp == `FR_RESP_RETRY; // [R12] [R13]
		next_pgood_pin      = power_ok ~^ bus_address_pin_setup[`FR_PG_POL]; // [R9]
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			oc_d           <= 1'b0;
			strap_cnt      <= '0;
			strap_q        <= '0;
			bus_address    <= '0;
			fast_oc_status <= 1'b0;
			host_notify    <= 1'b0;
			output_en      <= 1'b0;
			fast_limit_sel <= 1'b0;
			pgood_pin      <= 1'b0;
		end else begin
			oc_d           <= oc_s;
			strap_cnt      <= next_strap_cnt;
			strap_q        <= next_strap_q;
			bus_address    <= next_bus_address;
			fast_oc_status <= next_fast_oc_status;
			host_notify    <= next_host_notify;
			output_en      <= next_output_en;
			fast_limit_sel <= next_fast_limit_sel;
			pgood_pin      <= next_pgood_pin;
		end
	end

	a_stored_ofs: assert property (!bus_address_pin_setup[`FR_OFS_EN] // [R7]
		|=> bus_address == $past(bus_address_pin_setup[31:24])
			+ {1'b0, $past(bus_address_pin_setup[23:17])}) else $error("stored offset address wrong");
	a_strap_ofs: assert property (bus_address_pin_setup[`FR_OFS_EN] // [R8]
		|=> bus_address == $past(bus_address_pin_setup[31:24]) + {1'b0, $past(strap_q)})
		else $error("strap offset address wrong");
	a_pgood_pol: assert property (1'b1 // [R9]
		|=> pgood_pin == ($past(power_ok) ~^ $past(bus_address_pin_setup[33])))
		else $error("power-good polarity wrong");
	a_ctrl_off: assert property (ctl_s != bus_address_pin_setup[`FR_CTL_POL] |=> !output_en) // [R10]
		else $error("output on while control inactive");
	a_fault_note: assert property ($rose(oc_s) |=> host_notify && fast_oc_status) // [R11]
		else $error("fault not flagged");
	a_ignore_runs: assert property (resp == `FR_RESP_IGNORE && state == frc_pkg::FRC_IDLE // [R12]
		&& ctl_act |=> output_en && !fast_limit_sel) else $error("ignore code stopped output");
endmodule // frc_regs

// >>> sim/frc_host_model.sv
// behavioural host that issues configuration commands to the block
`timescale 1ns/1ps
module frc_host_model (
	// clock
	input  wire logic        sys_clk,
	// request
	output logic             cmd_valid,
	output logic             cmd_write,
	output logic [7:0]       cmd_code,
	output logic [33:0]      cmd_wdata,
	// answer
	input  wire logic        cmd_ack,
	input  wire logic        cmd_err,
	input  wire logic [33:0] cmd_rdata
);
	initial begin
		cmd_valid = 1'b0;
		cmd_write = 1'b0;
		cmd_code  = 8'h00;
		cmd_wdata = 34'h0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// one command; r and e are unknown when no answer comes in time
	task automatic xfer(input logic w, input logic [7:0] c, input logic [33:0] d,
		output logic [33:0] r, output logic e);
		int n;
		@(negedge sys_clk);
		cmd_valid = 1'b1;
		cmd_write = w;
		cmd_code  = c;
		cmd_wdata = d;
		@(negedge sys_clk);
		cmd_valid = 1'b0;
		// released lines carry junk so a stale value is never mistaken for data
		cmd_write = ~w;
		cmd_code  = ~c;
		cmd_wdata = ~d;
		n = 0;
		while (cmd_ack !== 1'b1 && n < 4) begin
			@(negedge sys_clk);
			n++;
		end
		r = (cmd_ack === 1'b1) ? cmd_rdata : 34'hx;
		e = (cmd_ack === 1'b1) ? cmd_err : 1'bx;
	endtask
endmodule // frc_host_model

// >>> sim/tb.sv
// self-checking bench for the fault/retry configuration registers
`timescale 1ns/1ps
module tb;
	localparam int MS = 4;
	logic        sys_clk = 1'b0;
	logic        rst = 1'b1;
	logic        clear_fault = 1'b0;
	logic        ctrl_pin = 1'b0;
	logic        fast_oc_pin = 1'b0;
	logic [6:0]  addr_strap = 7'h15;
	logic        power_ok = 1'b1;
	logic        cmd_valid, cmd_write, cmd_ack, cmd_err;
	logic [7:0]  cmd_code, bus_address;
	logic [33:0] cmd_wdata, cmd_rdata;
	logic        pgood_pin, output_en, diode_emu_en, fast_limit_sel;
	logic        fast_oc_status, host_notify;
	logic [1:0]  vout_unit, vin_unit, iout_unit, temp_unit;
	int          bad_count = 0;
	int          n_tests = 0;
	int          notes = 0;

	always #2 sys_clk = ~sys_clk;
	always @(posedge sys_clk) if (host_notify === 1'b1) notes++;

	frc_host_model u_host (.sys_clk(sys_clk), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
		.cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_ack(cmd_ack), .cmd_err(cmd_err),
		.cmd_rdata(cmd_rdata));

	frc_regs #(.MS_CYCLES(MS)) u_dut (.sys_clk(sys_clk), .rst(rst),
		.cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code),
		.cmd_wdata(cmd_wdata), .clear_fault(clear_fault), .cmd_ack(cmd_ack),
		.cmd_err(cmd_err), .cmd_rdata(cmd_rdata), .ctrl_pin(ctrl_pin),
		.fast_oc_pin(fast_oc_pin), .addr_strap(addr_strap), .pgood_pin(pgood_pin),
		.power_ok(power_ok), .output_en(output_en), .diode_emu_en(diode_emu_en),
		.fast_limit_sel(fast_limit_sel), .bus_address(bus_address), .vout_unit(vout_unit),
		.vin_unit(vin_unit), .iout_unit(iout_unit), .temp_unit(temp_unit),
		.fast_oc_status(fast_oc_status), .host_notify(host_notify));

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [33:0] exp, input logic [33:0] got);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge sys_clk);
	endtask

	function automatic logic [33:0] unmapped(input logic [7:0] c);
		return {33'h0, !(c inside {8'hc5, 8'hc8, 8'hc9, 8'hca})};
	endfunction

	task automatic wr(input logic [7:0] c, input logic [33:0] d);
		logic [33:0] r;
		logic        e;
		u_host.xfer(1'b1, c, d, r, e);
		chk("write error flag", unmapped(c), {33'h0, e});
	endtask

	task automatic rd(input logic [7:0] c, input logic [33:0] exp);
		logic [33:0] r;
		logic        e;
		u_host.xfer(1'b0, c, 34'h0, r, e);
		chk("read data", exp, r);
		chk("read error flag", unmapped(c), {33'h0, e});
	endtask

	// bounded wait; a change sooner than lo cycles counts as a mismatch
	task automatic wait_en(input logic v, input int lo, input int hi);
		int n;
		n = 0;
		while (output_en !== v && n < hi) begin
			@(negedge sys_clk);
			n++;
		end
		chk("output enable", {33'h0, v}, {33'h0, output_en});
		chk("enable delay in range", 34'h1, {33'h0, n >= lo});
	endtask

	// pin dropped first so the synchronised fault is gone before the clear
	task automatic clr;
		fast_oc_pin = 1'b0;
		cyc(4);
		clear_fault = 1'b1;
		cyc(1);
		clear_fault = 1'b0;
		cyc(3);
	endtask

	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		logic [7:0] pat [2] = '{8'h1b, 8'he4};
		logic [2:0] rc [2] = '{3'h1, 3'h7};
		int         un [6] = '{0, 0, 1, 2, 3, 0};
		int         rt [6] = '{0, 1, 1, 0, 0, 7};
		int         d;
		int         n0;
		cyc(4);
		rst = 1'b0;
		cyc(4);
		rd(8'hc5, 34'h0);
		rd(8'hc8, 34'h0);
		rd(8'hc9, 34'h0);
		rd(8'hca, 34'h0);
		rd(8'hc6, 34'h0);
		wr(8'hcb, 34'h3_ffff_ffff);
		$display("test reset values done");

		wr(8'hc5, 34'h3_ffff_ff01);
		chk("diode emulation", 34'h1, {33'h0, diode_emu_en});
		rd(8'hc5, 34'h01);
		wr(8'hc5, 34'h0);
		chk("diode emulation", 34'h0, {33'h0, diode_emu_en});
		$display("test regulation done");

		foreach (pat[i]) begin
			wr(8'hc8, {26'h0, pat[i]});
			chk("vout unit", {32'h0, pat[i][7:6]}, {32'h0, vout_unit});
			chk("vin unit", {32'h0, pat[i][5:4]}, {32'h0, vin_unit});
			chk("iout unit", {32'h0, pat[i][3:2]}, {32'h0, iout_unit});
			chk("temp unit", {32'h0, pat[i][1:0]}, {32'h0, temp_unit});
			rd(8'hc8, {26'h0, pat[i]});
		end
		$display("test time units done");

		wr(8'hc9, {2'b11, 8'h40, 7'h0a, 1'b0, 16'h0});
		cyc(2);
		chk("bus address", 34'h4a, {26'h0, bus_address});
		rd(8'hc9, {2'b11, 8'h40, 7'h0a, 1'b0, 16'h0});
		wr(8'hc9, {2'b11, 8'hf0, 7'h0a, 1'b1, 16'h0});
		cyc(2);
		chk("bus address", 34'h05, {26'h0, bus_address});
		for (int k = 0; k < 4; k++) begin
			power_ok = k[0];
			ctrl_pin = k[0];
			wr(8'hc9, {k[1], k[1], 32'h0});
			cyc(4);
			chk("power good pin", {33'h0, k[1] ~^ k[0]}, {33'h0, pgood_pin});
			chk("output enable", {33'h0, k[1] ~^ k[0]}, {33'h0, output_en});
		end
		$display("test address and polarity done");

		// long timing fields so a wrongly taken retry path would show
		wr(8'hc8, 34'h0);
		wr(8'hca, 34'h07);
		n0 = notes;
		fast_oc_pin = 1'b1;
		cyc(6);
		chk("fault status", 34'h1, {33'h0, fast_oc_status});
		chk("notify count", 34'(n0 + 1), 34'(notes));
		cyc(600);
		chk("fast limit select", 34'h0, {33'h0, fast_limit_sel});
		chk("output enable", 34'h1, {33'h0, output_en});
		clr;
		chk("fault status", 34'h0, {33'h0, fast_oc_status});
		$display("test ignore response done");

		for (int i = 0; i < 6; i++) begin
			d = ((1 << (un[i] == 3 ? 8 : 2 * un[i])) << rt[i]) * MS;
			wr(8'hc8, {30'h0, un[i][1:0], 2'b00});
			wr(8'hca, {26'h0, 2'b11, 3'b000, rt[i][2:0]});
			n0 = notes;
			fast_oc_pin = 1'b1;
			cyc(5);
			chk("fast limit select", 34'h1, {33'h0, fast_limit_sel});
			chk("notify count", 34'(n0 + 1), 34'(notes));
			wait_en(1'b0, d - 2, d + 4);
			cyc(d + 10);
			chk("output enable", 34'h0, {33'h0, output_en});
			clr;
			chk("output enable", 34'h1, {33'h0, output_en});
		end
		$display("test latch off done");

		wr(8'hc8, 34'h0);
		foreach (rc[j]) begin
			wr(8'hca, {26'h0, 2'b11, rc[j], 3'b001});
			fast_oc_pin = 1'b1;
			cyc(5);
			wait_en(1'b0, 6, 12);
			repeat (rc[j] == 3'h7 ? 3 : 1) begin
				wait_en(1'b1, 6, 12);
				wait_en(1'b0, 6, 12);
			end
			if (rc[j] == 3'h7)
				fast_oc_pin = 1'b0;
			cyc(30);
			chk("output enable", {33'h0, rc[j] == 3'h7}, {33'h0, output_en});
			clr;
		end
		$display("test retries done");
		complete_run;
	end

	initial begin
		#200000;
		bad_count++;
		$display("[FAIL] watchdog expected finish seen timeout");
		complete_run;
	end
endmodule // tb
